/* File: lcd_shared_gpio_ports_test.sv */
// Self-checking bench for the LCD-shared GPIO ports
`timescale 1ns/1ps
`default_nettype none
module lcd_shared_gpio_ports_test;
  import lsgp_pkg::*;
  logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, lcd = 0;
  logic [1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, fi, fo, foe, fsa, fb = '0;
  logic [5:0] gi, go, goe, gsa, gb = '0;
  logic [41:28] seg = '0;
  logic [7:0] fd, fv, gd, gv, fs, gs, fe;
  int err_count = 0, checks_done = 0;
  always #20 core_clk = ~core_clk;
  lsgp_top dut_u (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .lcd_global_enable(lcd), .segment_enable_bit(seg),
    .first_port_pins_in(fi), .first_port_pins_out(fo),
    .first_port_pins_oe(foe), .first_port_seg_active(fsa),
    .second_port_pins_in(gi), .second_port_pins_out(go),
    .second_port_pins_oe(goe), .second_port_seg_active(gsa));
  lsgp_pins_model #(.W(8)) fm_u (.pins_out(fo), .pins_oe(foe),
    .board_drive(fb), .pins_in(fi));
  lsgp_pins_model #(.W(6)) gm_u (.pins_out(go), .pins_oe(goe),
    .board_drive(gb), .pins_in(gi));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    err_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'h00f0e026));
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    rd(LSGP_OFS_F_DIR, LSGP_F_DIR_RST);
    rd(LSGP_OFS_G_DIR, {2'b00, LSGP_G_DIR_RST});
    chk(foe | goe, 8'h00);
    $display("Reset test done");
    repeat (40) begin
      fd = $urandom;
      fv = $urandom;
      gd = $urandom;
      gv = $urandom;
      @(posedge core_clk);
      lcd <= $urandom;
      seg <= $urandom;
      fb <= $urandom;
      gb <= $urandom;
      wr(LSGP_OFS_F_DATA, fv);
      wr(LSGP_OFS_G_DATA, gv);
      wr(LSGP_OFS_F_DIR, fd);
      wr(LSGP_OFS_G_DIR, gd);
      rd(LSGP_OFS_G_DIR, gd & LSGP_G_IMPL_MASK);
      rd(LSGP_OFS_F_DIR, fd);
      fs = lcd ? {seg[31:28], seg[35:32]} : 8'h00;
      gs = lcd ? {2'b00, seg[41:36]} : 8'h00;
      chk(fsa, fs);
      chk(gsa, gs);
      fe = ~fd & ~fs;
      chk(foe, fe);
      chk(fo, fv);
      chk(go, gv & 8'h3f);
      rd(LSGP_OFS_F_DATA, (fe & fv) | (~fe & fb));
      fe = ~gd & ~gs & 8'h3f;
      chk(goe, fe);
      rd(LSGP_OFS_G_DATA, ((fe & gv) | (~fe & gb)) & 8'h3f);
    end
    $display("Pin and segment test done");
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk(fo, fv);
    chk(go, gv & 8'h3f);
    chk(foe | goe, 8'h00);
    $display("Warm reset test done");
    final_report();
  end
endmodule
`default_nettype wire

/* File: lsgp_asserts.sv */
// Boundary checks for the LCD-shared GPIO ports
`timescale 1ns/1ps
`default_nettype none
module lsgp_asserts
  import lsgp_pkg::*;
#(parameter int unsigned F_PINS = 8, parameter int unsigned G_PINS = 6) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [LSGP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic lcd_global_enable,
  input wire logic [41:28] segment_enable_bit,
  input wire logic [F_PINS-1:0] first_port_pins_oe,
  input wire logic [F_PINS-1:0] first_port_seg_active,
  input wire logic [G_PINS-1:0] second_port_pins_oe,
  input wire logic [G_PINS-1:0] second_port_seg_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_f_seg_map: assert property (
    first_port_seg_active == ({8{lcd_global_enable}} &
    {segment_enable_bit[31:28], segment_enable_bit[35:32]}))
    else $error("first port segment map wrong");
  a_g_seg_map: assert property (
    second_port_seg_active == ({6{lcd_global_enable}} &
    segment_enable_bit[41:36])) else $error("second port segment map wrong");
  a_seg_no_drive: assert property (
    ((first_port_pins_oe & first_port_seg_active) == 8'h00) &&
    ((second_port_pins_oe & second_port_seg_active) == 6'h00))
    else $error("driver on while segment owns pin");
  a_rd_idle_zero: assert property (!$past(reg_rd) |->
    reg_rdata == 8'h00) else $error("read data outside read slot");
  a_g_upper_zero: assert property (reg_rd && reg_addr[1] |=>
    reg_rdata[7:6] == 2'b00) else $error("second port upper bits set");
  a_dir_reset: assert property ($rose(nrst) |->
    first_port_pins_oe == 8'h00 && second_port_pins_oe == 6'h00)
    else $error("pin driven after reset");
  a_f_dir_wr: assert property (
    reg_wr && reg_addr == LSGP_OFS_F_DIR |=> first_port_pins_oe ==
    (~$past(reg_wdata) & ~first_port_seg_active))
    else $error("first port enable off direction");
  a_g_dir_wr: assert property (
    reg_wr && reg_addr == LSGP_OFS_G_DIR |=> {2'b00, second_port_pins_oe} ==
    (~$past(reg_wdata) & {2'b00, ~second_port_seg_active}))
    else $error("second port enable off direction");
  c_seg_take: cover property (|first_port_seg_active);
  c_g_read: cover property (reg_rd && reg_addr == LSGP_OFS_G_DATA);
  c_all_out: cover property (first_port_pins_oe == 8'hff);
endmodule
bind lsgp_top lsgp_asserts #(.F_PINS(F_PINS), .G_PINS(G_PINS)) chk_u (
  .core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .lcd_global_enable, .segment_enable_bit, .first_port_pins_oe,
  .first_port_seg_active, .second_port_pins_oe, .second_port_seg_active);
`default_nettype wire

/* File: lsgp_pin_ctl.sv */
// Per-pin driver control: GPIO direction versus LCD segment takeover
`timescale 1ns/1ps
`default_nettype none
module lsgp_pin_ctl
  import lsgp_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [WIDTH-1:0] data_latch,
  input wire logic [WIDTH-1:0] dir_latch,
  input wire logic [WIDTH-1:0] seg_enable,
  input wire logic lcd_global_enable,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] seg_active
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      // Segment takeover disconnects the GPIO driver entirely
      assign seg_active[i] = lcd_global_enable & seg_enable[i];
      assign pin_oe[i] = ~dir_latch[i] & ~seg_active[i];
      assign pin_out[i] = data_latch[i];
    end
  endgenerate
endmodule
`default_nettype wire

/* File: lsgp_pins_model.sv */
// Board-side model of the port pins
`timescale 1ns/1ps
`default_nettype none
module lsgp_pins_model #(parameter int unsigned W = 8) (
  input wire logic [W-1:0] pins_out,
  input wire logic [W-1:0] pins_oe,
  input wire logic [W-1:0] board_drive,
  output logic [W-1:0] pins_in
);
  // Board level wins wherever the port lets go
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & board_drive);
endmodule
`default_nettype wire

/* File: lsgp_pkg.sv */
// Shared constants for the LCD-shared GPIO ports block
package lsgp_pkg;
  localparam int unsigned LSGP_ADDR_W = 2;
  localparam logic [1:0] LSGP_OFS_F_DATA = 2'h0;
  localparam logic [1:0] LSGP_OFS_F_DIR = 2'h1;
  localparam logic [1:0] LSGP_OFS_G_DATA = 2'h2;
  localparam logic [1:0] LSGP_OFS_G_DIR = 2'h3;
  localparam int unsigned LSGP_F_PINS = 8;
  localparam int unsigned LSGP_G_PINS = 6;
  localparam logic [7:0] LSGP_F_DIR_RST = 8'hff;
  localparam logic [5:0] LSGP_G_DIR_RST = 6'h3f;
  localparam logic [7:0] LSGP_G_IMPL_MASK = 8'h3f;
  localparam int unsigned LSGP_SYNC_STAGES = 2;
  // Segment numbers carried by each port, pin 0 first
  localparam int unsigned LSGP_F_SEG_LO = 32;
  localparam int unsigned LSGP_F_SEG_HI = 28;
  localparam int unsigned LSGP_G_SEG_BASE = 36;
  typedef enum logic [1:0] {
    LSGP_RD_IDLE = 2'b01,
    LSGP_RD_VALID = 2'b10
  } lsgp_rd_e;
endpackage

/* File: lsgp_sync.sv */
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module lsgp_sync
  import lsgp_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } lsgp_sync_s;
  lsgp_sync_s state_reg;
  lsgp_sync_s state_next;

  always_comb begin
    state_next.meta = async_in;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;
endmodule
`default_nettype wire

/* File: lsgp_top.sv */
// Two LCD-shared general-purpose I/O ports with register access
//
// How it works
// [RULE1] Each of the six second-port pins is set as input or output by its own direction bit.
// [RULE2] A second-port pin floats when its direction bit is 1 and is driven from its latch at 0.
// [RULE3] Reading a data register returns the synchronised pin levels, 1 high and 0 low.
// [RULE4] Upper two bits of the second-port registers read zero and ignore writes.
// [RULE5] Data latches are not cleared by the reset input and keep their value through it.
// [RULE6] Every reset sets all implemented direction bits to 1 so every pin is an input.
// [RULE7] First-port pins 0-3 carry segments 32-35 and pins 4-7 segments 28-31.
// [RULE8] Second-port pins 0-5 carry segments 36-41 in order.
// [RULE9] The first port has eight pins with a one-to-one eight-bit direction register.
// [RULE10] A first-port pin floats when its direction bit is 1, driven from its latch at 0.
// [RULE11] Global LCD enable with a pin's segment enable hands the pin to the segment driver.
// [RULE12] A data write updates the latch whatever the pin direction.
`timescale 1ns/1ps
`default_nettype none
module lsgp_top
  import lsgp_pkg::*;
#(
  parameter int unsigned F_PINS = LSGP_F_PINS,
  parameter int unsigned G_PINS = LSGP_G_PINS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [LSGP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic lcd_global_enable,
  input wire logic [41:28] segment_enable_bit,
  input wire logic [F_PINS-1:0] first_port_pins_in,
  output logic [F_PINS-1:0] first_port_pins_out,
  output logic [F_PINS-1:0] first_port_pins_oe,
  output logic [F_PINS-1:0] first_port_seg_active,
  input wire logic [G_PINS-1:0] second_port_pins_in,
  output logic [G_PINS-1:0] second_port_pins_out,
  output logic [G_PINS-1:0] second_port_pins_oe,
  output logic [G_PINS-1:0] second_port_seg_active
);
  // Latches kept apart from reset; the direction and read path are reset
  typedef struct packed {
    logic [7:0] f_dir;
    logic [5:0] g_dir;
    logic [7:0] rdata;
    lsgp_rd_e rd_state;
  } lsgp_ctl_s;
  typedef struct packed {
    logic [7:0] f_data;
    logic [5:0] g_data;
  } lsgp_lat_s;

  lsgp_ctl_s ctl_reg;
  lsgp_ctl_s ctl_next;
  lsgp_lat_s lat_reg;
  lsgp_lat_s lat_next;
  logic [F_PINS-1:0] f_sync;
  logic [G_PINS-1:0] g_sync;
  logic [F_PINS-1:0] f_seg_en;
  logic [G_PINS-1:0] g_seg_en;

  function automatic logic hit(input logic [LSGP_ADDR_W-1:0] a,
                               input logic [LSGP_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Pin levels cross in through two flops before any read
  lsgp_sync #(.WIDTH(F_PINS)) u_sync_f (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(first_port_pins_in),
    .sync_out(f_sync)
  );
  lsgp_sync #(.WIDTH(G_PINS)) u_sync_g (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(second_port_pins_in),
    .sync_out(g_sync)
  );

  // Segment map: pins 0-3 -> 32..35, pins 4-7 -> 28..31
  assign f_seg_en = {segment_enable_bit[LSGP_F_SEG_HI+3:LSGP_F_SEG_HI],
                     segment_enable_bit[LSGP_F_SEG_LO+3:LSGP_F_SEG_LO]}; // see [RULE7]
  assign g_seg_en = segment_enable_bit[LSGP_G_SEG_BASE+5:LSGP_G_SEG_BASE]; // see [RULE8]

  always_comb begin
    ctl_next = ctl_reg;
    lat_next = lat_reg;
    ctl_next.rd_state = LSGP_RD_IDLE;
    if (reg_wr) begin
      if (hit(reg_addr, LSGP_OFS_F_DATA)) begin
        lat_next.f_data = reg_wdata; // see [RULE12]
      end
      if (hit(reg_addr, LSGP_OFS_F_DIR)) begin
        ctl_next.f_dir = reg_wdata; // see [RULE9]
      end
      if (hit(reg_addr, LSGP_OFS_G_DATA)) begin
        lat_next.g_data = reg_wdata[5:0]; // see [RULE4]
      end
      if (hit(reg_addr, LSGP_OFS_G_DIR)) begin
        ctl_next.g_dir = reg_wdata[5:0]; // see [RULE1]
      end
    end
    if (reg_rd) begin
      ctl_next.rd_state = LSGP_RD_VALID;
      case (reg_addr)
        LSGP_OFS_F_DATA: begin
          ctl_next.rdata = f_sync; // see [RULE3]
        end
        LSGP_OFS_F_DIR: begin
          ctl_next.rdata = ctl_reg.f_dir;
        end
        LSGP_OFS_G_DATA: begin
          ctl_next.rdata = {2'h0, g_sync} & LSGP_G_IMPL_MASK; // see [RULE4]
        end
        LSGP_OFS_G_DIR: begin
          ctl_next.rdata = {2'h0, ctl_reg.g_dir};
        end
        default: begin
          ctl_next.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctl_reg.f_dir <= LSGP_F_DIR_RST; // see [RULE6]
      ctl_reg.g_dir <= LSGP_G_DIR_RST; // see [RULE6]
      ctl_reg.rdata <= 8'h00;
      ctl_reg.rd_state <= LSGP_RD_IDLE;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // No reset branch: the latches hold through any reset pulse
  always_ff @(posedge core_clk) begin
    lat_reg <= lat_next; // see [RULE5]
  end

  // Read data stand only in the cycle after the strobe
  assign reg_rdata = (ctl_reg.rd_state == LSGP_RD_VALID) ? ctl_reg.rdata
                                                        : 8'h00;

  lsgp_pin_ctl #(.WIDTH(F_PINS)) u_pins_f (
    .data_latch(lat_reg.f_data),
    .dir_latch(ctl_reg.f_dir),
    .seg_enable(f_seg_en),
    .lcd_global_enable(lcd_global_enable),
    .pin_out(first_port_pins_out),
    .pin_oe(first_port_pins_oe), // see [RULE10] [RULE11]
    .seg_active(first_port_seg_active)
  );
  lsgp_pin_ctl #(.WIDTH(G_PINS)) u_pins_g (
    .data_latch(lat_reg.g_data),
    .dir_latch(ctl_reg.g_dir),
    .seg_enable(g_seg_en),
    .lcd_global_enable(lcd_global_enable),
    .pin_out(second_port_pins_out),
    .pin_oe(second_port_pins_oe), // see [RULE2] [RULE11]
    .seg_active(second_port_seg_active)
  );
endmodule
`default_nettype wire
